// ### design/error_queue.sv
`timescale 1ns/100ps
`include "status_defines.svh"
module error_queue (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic push,
  input wire logic [15:0] push_code,
  input wire logic pop,
  output logic [15:0] err_code,
  output logic empty,
  output logic full
);
  status_pkg::errq_t s_r, s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (pop)
    begin
      // oldest first, zero code when empty
      if (s_r.cnt != 3'h0)
      begin
        s_nxt.out = s_r.mem[s_r.rd];
        s_nxt.rd = s_r.rd + 2'h1;
      end
      else
        s_nxt.out = `ERR_NONE;
    end
    // a full queue drops new entries so the oldest survive
    if (push && s_r.cnt != 3'(`ERRQ_DEPTH))
    begin
      s_nxt.mem[s_r.wr] = push_code;
      s_nxt.wr = s_r.wr + 2'h1;
    end
    s_nxt.cnt = s_r.cnt + 3'(push && s_r.cnt != 3'(`ERRQ_DEPTH)) - 3'(pop && s_r.cnt != 3'h0);
  end
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  assign err_code = s_r.out;
  assign empty = s_r.cnt == 3'h0;
  assign full = s_r.cnt == 3'(`ERRQ_DEPTH);
  property p_fifo_head;
    @(posedge clk_sys) disable iff (!rstn)
    pop && s_r.cnt != 3'h0 |=> err_code == $past(s_r.mem[s_r.rd]);
  endproperty
  a_fifo_head: assert property (p_fifo_head) else $error("error queue head not returned");
  property p_empty_zero;
    @(posedge clk_sys) disable iff (!rstn)
    pop && s_r.cnt == 3'h0 |=> err_code == `ERR_NONE;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty error queue gave nonzero");
endmodule

// ### design/status_byte.sv
// Operation
// - bit 4 is one while the output queue holds unread data.
// - bit 5 set when any enabled standard event bit is set.
// - on a service condition set bit 6 and assert the service request line.
// - serial poll returns request flag in bit 6; query returns master summary.
// - request flag and master summary always equal.
// - master summary asserted while any reason for service is pending.
// - error query returns oldest queue entry, then removes it.
// - empty error queue answers code zero, no error.
// - eight-bit enable mask selects which summary bits request service.
// - event bits ANDed with enables and ORed into bit 5.
// - event bits at 0,2,3,4,5,7; others read zero.
`timescale 1ns/100ps
`include "status_defines.svh"
module status_byte (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic msg_pending_pin,
  input wire logic [7:0] event_set,
  input wire logic sre_we,
  input wire logic [7:0] sre_wdata,
  input wire logic ese_we,
  input wire logic [7:0] ese_wdata,
  input wire logic esr_read,
  input wire logic serial_poll_read,
  input wire logic stb_query,
  input wire logic err_push,
  input wire logic [15:0] err_push_code,
  input wire logic err_query,
  output logic [7:0] poll_byte,
  output logic [7:0] stb_byte,
  output logic [7:0] esr_byte,
  output logic [7:0] sre_byte,
  output logic [7:0] ese_byte,
  output logic [15:0] err_code,
  output logic err_empty,
  output logic err_full,
  output logic srq
);
  status_pkg::stat_t s_r, s_nxt;
  logic msg_wait_s1_r, msg_wait_s2_r;
  logic msg_wait_r;
  logic [7:0] summary;
  logic [7:0] summary_nxt;
  logic master_sum;
  logic event_sum;
  logic [7:0] poll_r, stb_r;

  function automatic logic masked_or(input logic [7:0] v, input logic [7:0] m);
    masked_or = |(v & m);
  endfunction

  // bit 6 stays zero so the request flag never feeds itself
  function automatic logic [7:0] build_summary(input logic pending, input logic [7:0] events,
    input logic [7:0] enables);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_MSG_WAIT] = pending;
    b[`BIT_EVENT_SUM] = masked_or(events, enables);
    return b;
  endfunction

  // the pending flag comes from the output queue logic elsewhere; synchronise
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      msg_wait_s1_r <= 1'b0;
      msg_wait_s2_r <= 1'b0;
    end
    else
    begin
      msg_wait_s1_r <= msg_pending_pin;
      msg_wait_s2_r <= msg_wait_s1_r;
    end

  // one extra stage: the request flag sees the level a cycle early, costing one cycle of latency
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      msg_wait_r <= 1'b0;
    else
      msg_wait_r <= msg_wait_s2_r;

  assign event_sum = masked_or(s_r.esr, s_r.ese);
  assign summary = build_summary(msg_wait_r, s_r.esr, s_r.ese);
  assign master_sum = masked_or(summary, s_r.sre);

  always_comb
  begin
    s_nxt = s_r;
    summary_nxt = 8'h00;
    if (sre_we)
      s_nxt.sre = sre_wdata;
    if (ese_we)
      s_nxt.ese = ese_wdata;
    // reading clears; a new event in the same cycle still lands
    if (esr_read)
      s_nxt.esr = 8'h00;
    s_nxt.esr = s_nxt.esr | (event_set & `EV_USED_MASK);
    // built from next-state values, so the flag equals the master summary in every cycle
    summary_nxt = build_summary(msg_wait_s2_r, s_nxt.esr, s_nxt.ese);
    s_nxt.req_flag = masked_or(summary_nxt, s_nxt.sre);
  end

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      s_r <= '0;
      poll_r <= 8'h00;
      stb_r <= 8'h00;
    end
    else
    begin
      s_r <= s_nxt;
      if (serial_poll_read)
        poll_r <= summary | {1'b0, s_r.req_flag, 6'h00};
      if (stb_query)
        stb_r <= summary | {1'b0, master_sum, 6'h00};
    end

  assign poll_byte = poll_r;
  assign stb_byte = stb_r;
  assign esr_byte = s_r.esr;
  assign sre_byte = s_r.sre;
  assign ese_byte = s_r.ese;
  assign srq = s_r.req_flag;

  error_queue u_errq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .push(err_push),
    .push_code(err_push_code),
    .pop(err_query),
    .err_code(err_code),
    .empty(err_empty),
    .full(err_full)
  );

  // checks on the summary byte and its two read paths
  property p_msg_wait;
    @(posedge clk_sys) disable iff (!rstn)
    stb_query |=> stb_byte[`BIT_MSG_WAIT] == $past(msg_wait_r);
  endproperty
  a_msg_wait: assert property (p_msg_wait) else $error("bit 4 does not follow pending message");

  property p_event_sum;
    @(posedge clk_sys) disable iff (!rstn)
    (event_set & ese_byte & `EV_USED_MASK) != 8'h00 && !ese_we |=> event_sum;
  endproperty
  a_event_sum: assert property (p_event_sum) else $error("enabled event lost from bit 5");

  property p_esr_hold;
    @(posedge clk_sys) disable iff (!rstn)
    !esr_read |=> (esr_byte & $past(esr_byte)) == $past(esr_byte);
  endproperty
  a_esr_hold: assert property (p_esr_hold) else $error("event bit lost without a read");

  property p_stb_event;
    @(posedge clk_sys) disable iff (!rstn)
    stb_query |=> stb_byte[`BIT_EVENT_SUM] == $past(event_sum);
  endproperty
  a_stb_event: assert property (p_stb_event) else $error("bit 5 does not follow event summary");

  property p_srq;
    @(posedge clk_sys) disable iff (!rstn)
    master_sum |-> srq;
  endproperty
  a_srq: assert property (p_srq) else $error("service request not raised");

  property p_poll;
    @(posedge clk_sys) disable iff (!rstn)
    serial_poll_read |=> poll_byte[`BIT_SVC_REQ] == $past(srq);
  endproperty
  a_poll: assert property (p_poll) else $error("poll bit 6 not request flag");

  property p_stb_master;
    @(posedge clk_sys) disable iff (!rstn)
    stb_query |=> stb_byte[`BIT_SVC_REQ] == $past(master_sum);
  endproperty
  a_stb_master: assert property (p_stb_master) else $error("query bit 6 not master summary");

  property p_eq;
    @(posedge clk_sys) disable iff (!rstn)
    srq == master_sum;
  endproperty
  a_eq: assert property (p_eq) else $error("request and master summary differ");

  property p_master;
    @(posedge clk_sys) disable iff (!rstn)
    master_sum == ((event_sum & sre_byte[5]) | (msg_wait_r & sre_byte[4]));
  endproperty
  a_master: assert property (p_master) else $error("master summary wrong");

  property p_zero;
    @(posedge clk_sys) disable iff (!rstn)
    stb_query |=> (stb_byte & 8'h8F) == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("unused status bits not zero");

  property p_poll_zero;
    @(posedge clk_sys) disable iff (!rstn)
    serial_poll_read |=> (poll_byte & 8'h8F) == 8'h00;
  endproperty
  a_poll_zero: assert property (p_poll_zero) else $error("unused poll bits not zero");

  property p_ev;
    @(posedge clk_sys) disable iff (!rstn)
    (esr_byte & 8'h42) == 8'h00;
  endproperty
  a_ev: assert property (p_ev) else $error("unused event bit set");

  // main scenarios
  c_srq: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(srq));
  c_poll: cover property (@(posedge clk_sys) disable iff (!rstn) serial_poll_read && srq);
  c_err: cover property (@(posedge clk_sys) disable iff (!rstn) err_query && !err_empty);
  c_stb_req: cover property (@(posedge clk_sys) disable iff (!rstn) stb_query && master_sum);
  c_event: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(event_sum));
endmodule

// ### inc/status_defines.svh
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH
`define BIT_MSG_WAIT 4
`define BIT_EVENT_SUM 5
`define BIT_SVC_REQ 6
`define EV_OPC 0
`define EV_QYE 2
`define EV_DDE 3
`define EV_EXE 4
`define EV_CME 5
`define EV_PON 7
`define EV_USED_MASK 8'hBD
`define SRE_RESET 8'h00
`define ESE_RESET 8'h00
`define ERRQ_DEPTH 4
`define ERRQ_AW 2
`define ERR_NONE 16'h0000
`endif

// ### inc/status_pkg.sv
package status_pkg;
  typedef struct packed {
    logic [7:0] sre;
    logic [7:0] ese;
    logic [7:0] esr;
    logic req_flag;
  } stat_t;
  typedef struct packed {
    logic [3:0][15:0] mem;
    logic [1:0] rd;
    logic [1:0] wr;
    logic [2:0] cnt;
    logic [15:0] out;
  } errq_t;
endpackage

// ### sim/bus_controller_model.sv
`timescale 1ns/100ps
module bus_controller_model (
  input wire logic clk_sys,
  input wire logic srq,
  input wire logic [7:0] poll_byte,
  output logic serial_poll_read,
  output logic [7:0] poll_seen,
  output logic poll_done
);
  initial
  begin
    serial_poll_read = 1'b0;
    poll_seen = 8'h00;
    poll_done = 1'b0;
  end
  // a single poll on the first request line assertion only (poll_done never clears), taken back in the handler
  always @(negedge clk_sys)
  begin
    if (serial_poll_read)
    begin
      serial_poll_read = 1'b0;
      poll_seen = poll_byte;
      poll_done = 1'b1;
    end
    else if (srq === 1'b1 && !poll_done)
      serial_poll_read = 1'b1;
  end
endmodule

// ### sim/status_byte_and_error_queue_tb_top.sv
`timescale 1ns/100ps
module status_byte_and_error_queue_tb_top;
  logic clk_sys = 0, rstn = 0, msg_pending_pin = 0, sre_we = 0, ese_we = 0, esr_read = 0;
  logic stb_query = 0, err_push = 0, err_query = 0, serial_poll_read, srq, err_empty, err_full, poll_done;
  logic [7:0] event_set = 8'h00, sre_wdata = 8'h00, ese_wdata = 8'h00;
  logic [7:0] poll_byte, stb_byte, esr_byte, sre_byte, ese_byte, poll_seen;
  logic [15:0] err_push_code = 16'h0000, err_code;
  int err_total = 0, total_checks = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  status_byte dut_u (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .msg_pending_pin(msg_pending_pin),
    .event_set(event_set),
    .sre_we(sre_we),
    .sre_wdata(sre_wdata),
    .ese_we(ese_we),
    .ese_wdata(ese_wdata),
    .esr_read(esr_read),
    .serial_poll_read(serial_poll_read),
    .stb_query(stb_query),
    .err_push(err_push),
    .err_push_code(err_push_code),
    .err_query(err_query),
    .poll_byte(poll_byte),
    .stb_byte(stb_byte),
    .esr_byte(esr_byte),
    .sre_byte(sre_byte),
    .ese_byte(ese_byte),
    .err_code(err_code),
    .err_empty(err_empty),
    .err_full(err_full),
    .srq(srq)
  );
  bus_controller_model ctl_u (
    .clk_sys(clk_sys),
    .srq(srq),
    .poll_byte(poll_byte),
    .serial_poll_read(serial_poll_read),
    .poll_seen(poll_seen),
    .poll_done(poll_done)
  );
  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task q(input logic [7:0] e);
    @(negedge clk_sys) stb_query = 1;
    @(negedge clk_sys) stb_query = 0;
    chk(stb_byte, e);
  endtask
  task eq(input logic [15:0] e);
    @(negedge clk_sys) err_query = 1;
    @(negedge clk_sys) err_query = 0;
    chk(err_code, e);
  endtask
  task setm(input logic s, input logic [7:0] v);
    @(negedge clk_sys);
    sre_we = s;
    ese_we = !s;
    sre_wdata = v;
    ese_wdata = v;
    @(negedge clk_sys);
    sre_we = 0;
    ese_we = 0;
  endtask
  task ev(input logic [7:0] v, input logic clr);
    @(negedge clk_sys) esr_read = clr;
    @(negedge clk_sys) esr_read = 0;
    event_set = v;
    @(negedge clk_sys) event_set = 8'h00;
    @(negedge clk_sys);
  endtask
  // bound well above the fewer than a hundred cycles the sequence needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rstn = 1;
    q(8'h00);
    chk(sre_byte, 8'h00);
    eq(8'h00);
    chk({7'h00, err_empty}, 8'h01);
    msg_pending_pin = 1;
    repeat (4) @(negedge clk_sys);
    q(8'h10);
    setm(0, 8'hFF);
    ev(8'hFF, 0);
    chk(esr_byte, 8'hBD);
    q(8'h30);
    setm(0, 8'h04);
    chk(ese_byte, 8'h04);
    ev(8'h01, 1);
    q(8'h10);
    chk({7'h00, srq}, 8'h00);
    setm(1, 8'h10);
    for (int i = 0; i < 20 && poll_done !== 1'b1; i++)
      @(negedge clk_sys);
    chk(poll_seen, 8'h50);
    chk(sre_byte, 8'h10);
    chk({7'h00, srq}, 8'h01);
    q(8'h50);
    setm(1, 8'h40);
    repeat (2) @(negedge clk_sys);
    q(8'h10);
    chk({7'h00, srq}, 8'h00);
    for (int i = 1; i <= 5; i++)
    begin
      @(negedge clk_sys) err_push = 1;
      err_push_code = 16'(i);
    end
    @(negedge clk_sys) err_push = 0;
    chk({7'h00, err_full}, 8'h01);
    for (int i = 1; i <= 4; i++)
      eq(16'(i));
    eq(8'h00);
    print_verdict;
  end
endmodule
